// *** hdl/rsc_reset_source_control.sv ***
// Reset source control: reset pin filter, detectors, power-up timer, cause flags
//
// Behaviour
// - Device stays in hard reset while the external reset pin is low.
// - A noise filter ignores short low pulses on the reset pin.
// - No internal reset drives the reset pin; it is input only.
// - A supply rise past threshold gives a power-on reset from initial state.
// - Power-on flag clears on every power-on reset and main supply brown-out, untouched by other resets.
// - Hardware never sets the power-on flag; software writes it to one.
// - At most one brown-out detector is active at any time.
// - Outside deep sleep the core detector holds reset while core supply is low.
// - After core recovery reset stays asserted until the power-up timer expires.
// - In deep sleep the main detector monitors only when its enable bit is one.
// - Main supply brown-out gives power-on-like reset and clears both holding registers.
// - On deep-sleep brown-out output pins tri-state and deep sleep is left.
// - After recovery execution resumes without setting the deep-sleep wake flag.
// - Low-voltage variants keep the core detector permanently disabled.
// - Main detector on when enable bit set and low-voltage or in deep sleep.
// - Crossing the arming level alone never causes a reset.
// - Brown-out flag clears on every core brown-out and every power-on reset.
// - Without the core regulator, power-on still clears the brown-out flag.
`timescale 1ns/1ps

module rsc_reset_source_control #(
  parameter int POWERUP_CYCLES = rsc_pkg::PWRT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic external_reset_pin_n,
  input wire logic supply_good,
  input wire logic core_below_level,
  input wire logic main_below_level,
  input wire logic main_below_arming,
  input wire logic low_voltage_variant,
  input wire logic [7:0] config_word_three_low,
  input wire logic wake_event,
  input wire logic [rsc_pkg::ADDR_WIDTH-1:0] addr,
  input wire logic [rsc_pkg::DATA_WIDTH-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [rsc_pkg::DATA_WIDTH-1:0] rdata,
  output logic sys_reset_n,
  output logic pins_tristate,
  output logic deep_sleep_active,
  output logic deep_sleep_wake_flag,
  output logic core_bor_active,
  output logic main_bor_active
);
  import rsc_pkg::*;

  // Counter constants at their own widths
  localparam logic [FILTER_WIDTH-1:0] FILTER_LIMIT = FILTER_WIDTH'(FILTER_CYCLES);
  localparam logic [PWRT_WIDTH-1:0] PWRT_LOAD = PWRT_WIDTH'(POWERUP_CYCLES - 1);
  localparam logic [PWRT_WIDTH-1:0] PWRT_ZERO = '0;
  localparam logic [FILTER_WIDTH-1:0] FILTER_ZERO = '0;
  localparam logic [FILTER_WIDTH-1:0] FILTER_STEP = FILTER_WIDTH'(1);
  localparam logic [PWRT_WIDTH-1:0] PWRT_STEP = PWRT_WIDTH'(1);

  // Sequencer, filter and timer state
  rsc_state_type state;
  rsc_state_type next_state;
  logic [FILTER_WIDTH-1:0] low_count;
  logic ext_reset;
  logic supply_good_q;
  logic por_event;
  logic [PWRT_WIDTH-1:0] pwrt_count;
  logic main_cause;
  // Software-visible flags and holding registers
  logic por_flag;
  logic bor_flag;
  logic [7:0] hold_0;
  logic [7:0] hold_1;
  // Decoded events and detector enables
  logic dsbor_enable;
  logic next_core_on;
  logic next_main_on;
  logic core_trip;
  logic ds_trip;
  logic core_still_low;
  logic main_still_low;
  logic ds_enter;
  logic wake_hit;
  logic held;

  // Address match for a write strobe
  function automatic logic wr_hit(input logic stb, input logic [11:0] a,
                                  input logic [11:0] target);
    wr_hit = stb && (a == target);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // External reset pin filter

  // Count consecutive low samples; a short pulse never reaches the limit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_count <= FILTER_ZERO;
    end else if (external_reset_pin_n) begin
      low_count <= FILTER_ZERO;
    end else if (low_count != FILTER_LIMIT) begin
      low_count <= low_count + FILTER_STEP;
    end
  end

  // Held while the pin stays low past the filter; the pin itself is never driven
  assign ext_reset = (low_count == FILTER_LIMIT);

  //////////////////////////////////////////////////////////////////////////////
  // Detector enables and trip events

  assign dsbor_enable = config_word_three_low[BIT_DSBOR_ENABLE];

  // Core detector off in deep sleep and on low-voltage parts
  assign next_core_on = !low_voltage_variant && (next_state != ST_DEEP_SLEEP) &&
                        (next_state != ST_POWER_DOWN);
  // Main detector only with enable bit, on low-voltage parts or in deep sleep
  assign next_main_on = dsbor_enable && (low_voltage_variant ||
                        next_state == ST_DEEP_SLEEP) &&
                        (next_state != ST_POWER_DOWN);

  // Supply rise edge marks a power-on reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      supply_good_q <= 1'b0;
    end else begin
      supply_good_q <= supply_good;
    end
  end

  assign por_event = supply_good && !supply_good_q;

  // Trips only on the threshold comparators; arming level is ignored here
  assign core_trip = core_bor_active && core_below_level;
  assign ds_trip = main_bor_active && main_below_level;
  assign core_still_low = core_below_level && !low_voltage_variant;
  assign main_still_low = main_below_level && main_cause;
  assign ds_enter = wr_hit(wr, addr, ADDR_MODE) && wdata[BIT_MODE_DS_ENTER];
  assign wake_hit = wake_event && (state == ST_DEEP_SLEEP);

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next state of the power and reset sequence
  always_comb begin
    next_state = state;
    case (state)
      ST_POWER_DOWN: begin
        if (supply_good) begin
          next_state = ST_TIMER;
        end
      end
      ST_HOLD: begin
        if (!core_still_low && !main_still_low) begin
          next_state = ST_TIMER;
        end
      end
      ST_TIMER: begin
        if (core_trip || ds_trip) begin
          next_state = ST_HOLD;
        end else if (pwrt_count == PWRT_ZERO) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (core_trip || ds_trip) begin
          next_state = ST_HOLD;
        end else if (ds_enter && !ext_reset) begin
          next_state = ST_DEEP_SLEEP;
        end
      end
      ST_DEEP_SLEEP: begin
        if (ds_trip) begin
          next_state = ST_HOLD;
        end else if (wake_event) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_POWER_DOWN;
      end
    endcase
    if (!supply_good || por_event) begin
      next_state = ST_POWER_DOWN;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_POWER_DOWN;
    end else begin
      state <= next_state;
    end
  end

  // Remember whether the hold came from the main supply detector
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      main_cause <= 1'b0;
    end else if (ds_trip) begin
      main_cause <= 1'b1;
    end else if (next_state != ST_HOLD) begin
      main_cause <= 1'b0;
    end
  end

  // Power-up timer, loaded while held and counted down afterwards
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwrt_count <= PWRT_LOAD;
    end else if (state != ST_TIMER) begin
      pwrt_count <= PWRT_LOAD;
    end else if (pwrt_count != PWRT_ZERO) begin
      pwrt_count <= pwrt_count - PWRT_STEP;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset output and detector status

  // Any hold condition keeps the internal reset asserted
  assign held = (next_state == ST_POWER_DOWN) || (next_state == ST_HOLD) ||
                (next_state == ST_TIMER) || ext_reset;

  // Registered reset, released on a clock edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_reset_n <= 1'b0;
    end else begin
      sys_reset_n <= !held;
    end
  end

  // Detector enables, mutually exclusive by construction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_bor_active <= 1'b0;
      main_bor_active <= 1'b0;
    end else begin
      core_bor_active <= next_core_on;
      main_bor_active <= next_main_on;
    end
  end

  // Deep sleep indicator
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deep_sleep_active <= 1'b0;
    end else begin
      deep_sleep_active <= (next_state == ST_DEEP_SLEEP);
    end
  end

  // Pins float after a deep-sleep brown-out until software releases them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins_tristate <= 1'b0;
    end else if (ds_trip) begin
      pins_tristate <= 1'b1;
    end else if (wr_hit(wr, addr, ADDR_MODE) && wdata[BIT_MODE_PINS_TRISTATE]) begin
      pins_tristate <= 1'b0;
    end
  end

  // Wake flag set by a normal wake or a mode register write; brown-out recovery leaves it clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deep_sleep_wake_flag <= FLAG_RESET;
    end else if (ds_trip || por_event) begin
      deep_sleep_wake_flag <= FLAG_RESET;
    end else if (wake_hit) begin
      deep_sleep_wake_flag <= 1'b1;
    end else if (wr_hit(wr, addr, ADDR_MODE)) begin
      deep_sleep_wake_flag <= wdata[BIT_MODE_WAKE_FLAG];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cause flags

  // Power-on flag: hardware only clears, software writes it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_flag <= FLAG_RESET;
    end else if (por_event || ds_trip) begin
      por_flag <= FLAG_RESET;
    end else if (wr_hit(wr, addr, ADDR_RESET_CONTROL)) begin
      por_flag <= wdata[BIT_POR_FLAG];
    end
  end

  // Brown-out flag: cleared by core brown-out and power-on resets
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bor_flag <= FLAG_RESET;
    end else if (core_trip || por_event || ds_trip) begin
      bor_flag <= FLAG_RESET;
    end else if (wr_hit(wr, addr, ADDR_RESET_CONTROL)) begin
      bor_flag <= wdata[BIT_BOR_FLAG];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Deep-sleep holding registers

  // Lost on a power-on or deep-sleep brown-out; clear beats a write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_0 <= HOLD_RESET;
    end else if (por_event || ds_trip) begin
      hold_0 <= HOLD_RESET;
    end else if (wr_hit(wr, addr, ADDR_HOLD_0)) begin
      hold_0 <= wdata;
    end
  end

  // Second holding register, same rules as the first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_1 <= HOLD_RESET;
    end else if (por_event || ds_trip) begin
      hold_1 <= HOLD_RESET;
    end else if (wr_hit(wr, addr, ADDR_HOLD_1)) begin
      hold_1 <= wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read port

  // Read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= READ_IDLE;
    end else if (!rd) begin
      rdata <= READ_IDLE;
    end else begin
      rdata <= READ_IDLE;
      // Unused bits of a register read as zero
      case (addr)
        ADDR_HOLD_0: begin
          rdata <= hold_0;
        end
        ADDR_HOLD_1: begin
          rdata <= hold_1;
        end
        ADDR_RESET_CONTROL: begin
          rdata[BIT_POR_FLAG] <= por_flag;
          rdata[BIT_BOR_FLAG] <= bor_flag;
        end
        ADDR_STATUS: begin
          rdata[BIT_ST_CORE_BOR_ON] <= core_bor_active;
          rdata[BIT_ST_MAIN_BOR_ON] <= main_bor_active;
          rdata[BIT_ST_DEEP_SLEEP] <= deep_sleep_active;
          rdata[BIT_ST_ARMED] <= main_below_arming && main_bor_active;
          rdata[BIT_ST_EXT_RESET] <= ext_reset;
          rdata[BIT_ST_HELD] <= !sys_reset_n;
        end
        ADDR_MODE: begin
          rdata[BIT_MODE_WAKE_FLAG] <= deep_sleep_wake_flag;
          rdata[BIT_MODE_PINS_TRISTATE] <= pins_tristate;
        end
        default: begin
          rdata <= READ_IDLE;
        end
      endcase
    end
  end

endmodule

// *** hdl/rsc_pkg.sv ***
// Constants, register map and state type for the reset source control block
package rsc_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int FILTER_NS = 300;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRT_US = 65600;
  localparam int PWRT_CYCLES = (PWRT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRT_WIDTH = 20;
  localparam int FILTER_WIDTH = 2;

  // Register port widths
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 8;

  // Register offsets
  localparam logic [11:0] ADDR_HOLD_0 = 12'h0f4e;
  localparam logic [11:0] ADDR_HOLD_1 = 12'h0f4f;
  localparam logic [11:0] ADDR_RESET_CONTROL = 12'h0f60;
  localparam logic [11:0] ADDR_STATUS = 12'h0f61;
  localparam logic [11:0] ADDR_MODE = 12'h0f62;

  // Reset control register fields
  localparam int BIT_BOR_FLAG = 0;
  localparam int BIT_POR_FLAG = 1;

  // Configuration word three low field
  localparam int BIT_DSBOR_ENABLE = 2;

  // Mode register fields
  localparam int BIT_MODE_DS_ENTER = 0;
  localparam int BIT_MODE_WAKE_FLAG = 1;
  localparam int BIT_MODE_PINS_TRISTATE = 2;

  // Status register fields
  localparam int BIT_ST_CORE_BOR_ON = 0;
  localparam int BIT_ST_MAIN_BOR_ON = 1;
  localparam int BIT_ST_DEEP_SLEEP = 2;
  localparam int BIT_ST_ARMED = 3;
  localparam int BIT_ST_EXT_RESET = 4;
  localparam int BIT_ST_HELD = 5;

  // Reset values
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic FLAG_RESET = 1'b0;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_POWER_DOWN = 3'b000,
    ST_HOLD = 3'b001,
    ST_TIMER = 3'b010,
    ST_RUN = 3'b011,
    ST_DEEP_SLEEP = 3'b100
  } rsc_state_type;

endpackage

// *** sim/rsc_reset_source_control_asserts.sv ***
// Checker of port behaviour for the reset source control block
`timescale 1ns/1ps
module rsc_checker #(
  parameter int POWERUP_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic external_reset_pin_n,
  input wire logic supply_good,
  input wire logic core_below_level,
  input wire logic main_below_level,
  input wire logic low_voltage_variant,
  input wire logic [7:0] config_word_three_low,
  input wire logic rd,
  input wire logic [rsc_pkg::DATA_WIDTH-1:0] rdata,
  input wire logic sys_reset_n,
  input wire logic pins_tristate,
  input wire logic deep_sleep_active,
  input wire logic deep_sleep_wake_flag,
  input wire logic core_bor_active,
  input wire logic main_bor_active
);
  import rsc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  // Reset pin, detectors, power-on and read port
  a_pin_held_low: assert property ((!external_reset_pin_n)[*5] |=> !sys_reset_n)
    else $error("pin held low without reset");
  a_glitch_ignored: assert property (sys_reset_n && supply_good && !core_below_level
    && !main_below_level && $fell(external_reset_pin_n) ##1 external_reset_pin_n
    |=> sys_reset_n)
    else $error("short pin pulse caused reset");
  a_one_detector: assert property (!(core_bor_active && main_bor_active))
    else $error("both detectors on");
  a_core_trip_hold: assert property (core_bor_active && core_below_level
    |=> (!sys_reset_n)[*8])
    else $error("core brown-out not held");
  a_deep_trip: assert property (main_bor_active && main_below_level |=> !sys_reset_n
    && pins_tristate && !deep_sleep_active && !deep_sleep_wake_flag)
    else $error("deep brown-out response wrong");
  a_power_on_hold: assert property ($rose(supply_good) |=> (!sys_reset_n)[*8])
    else $error("power-on not held");
  a_lv_core_off: assert property ($stable(low_voltage_variant) && low_voltage_variant
    |-> !core_bor_active)
    else $error("core detector on in low-voltage variant");
  a_cfg_main_off: assert property ($stable(config_word_three_low)
    && !config_word_three_low[BIT_DSBOR_ENABLE] |-> !main_bor_active)
    else $error("main detector on while disabled");
  a_read_idle: assert property (!$past(rd) |-> rdata == READ_IDLE)
    else $error("read data outside read cycle");
  c_core_trip: cover property (core_bor_active && core_below_level);
  c_deep_trip: cover property (main_bor_active && main_below_level);
  c_glitch: cover property (sys_reset_n && $fell(external_reset_pin_n));
endmodule

bind rsc_reset_source_control rsc_checker #(.POWERUP_CYCLES(POWERUP_CYCLES)) rsc_checker_i (
  .clk(clk), .rstn(rstn), .external_reset_pin_n(external_reset_pin_n),
  .supply_good(supply_good), .core_below_level(core_below_level),
  .main_below_level(main_below_level), .low_voltage_variant(low_voltage_variant),
  .config_word_three_low(config_word_three_low), .rd(rd), .rdata(rdata),
  .sys_reset_n(sys_reset_n), .pins_tristate(pins_tristate),
  .deep_sleep_active(deep_sleep_active), .deep_sleep_wake_flag(deep_sleep_wake_flag),
  .core_bor_active(core_bor_active), .main_bor_active(main_bor_active));

// *** sim/rsc_far_side.sv ***
// Model of the reset pin circuit and the supply detectors
`timescale 1ns/1ps
module rsc_far_side (
  input wire logic clk,
  input wire logic pin_low,
  input wire logic supply_on,
  input wire logic core_sag,
  input wire logic main_sag,
  input wire logic main_dip,
  output logic external_reset_pin_n,
  output logic supply_good,
  output logic core_below_level,
  output logic main_below_level,
  output logic main_below_arming
);
  // Levels follow the commands one edge later; pin only driven from here
  always @(posedge clk) begin
    external_reset_pin_n <= !pin_low;
    supply_good <= supply_on;
    core_below_level <= core_sag;
    main_below_level <= main_sag;
    main_below_arming <= main_dip | main_sag; // Arming level lies above trip level
  end
endmodule

// *** sim/tb_rsc_reset_source_control.sv ***
// Self-checking testbench of the reset source control block
`timescale 1ns/1ps
module tb_rsc_reset_source_control;
  import rsc_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, lv = 1'b0, wake_event = 1'b0, wr = 1'b0, rd = 1'b0;
  logic pin_low = 1'b0, supply_on = 1'b1, core_sag = 1'b0, main_sag = 1'b0, main_dip = 1'b0;
  logic [7:0] cfg = 8'h00, wdata = 8'h00, r0, r1;
  logic [11:0] addr = 12'h0000;
  logic pin_n, sgood, core_lo, main_lo, main_arm;
  logic [7:0] rdata;
  logic sys_reset_n, pins_tristate, ds_act, wake_flag, core_on, main_on;
  int bad_count = 0, check_count = 0, n;
  rsc_reset_source_control #(.POWERUP_CYCLES(8)) rsc_reset_source_control_i (
    .clk(clk), .rstn(rstn), .external_reset_pin_n(pin_n), .supply_good(sgood),
    .core_below_level(core_lo), .main_below_level(main_lo), .main_below_arming(main_arm),
    .low_voltage_variant(lv), .config_word_three_low(cfg), .wake_event(wake_event),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sys_reset_n(sys_reset_n),
    .pins_tristate(pins_tristate), .deep_sleep_active(ds_act),
    .deep_sleep_wake_flag(wake_flag), .core_bor_active(core_on), .main_bor_active(main_on));
  rsc_far_side rsc_far_side_i (.clk(clk), .pin_low(pin_low), .supply_on(supply_on),
    .core_sag(core_sag), .main_sag(main_sag), .main_dip(main_dip),
    .external_reset_pin_n(pin_n), .supply_good(sgood), .core_below_level(core_lo),
    .main_below_level(main_lo), .main_below_arming(main_arm));
  ////////////////////////////////////////////////////////////////
  // Clock of 100 ns
  initial begin
    forever #50 clk = ~clk;
  end
  // Comparison of one value
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Expected reset control word from the two cause flags
  function automatic logic [7:0] flags_exp(input logic por, input logic bor);
    flags_exp = 8'h00;
    flags_exp[BIT_POR_FLAG] = por;
    flags_exp[BIT_BOR_FLAG] = bor;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Register bus cycles
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // Bounded wait for release; n counts cycles in reset
  task automatic wait_run();
    n = 0;
    while (sys_reset_n !== 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, sys_reset_n}, 8'h01);
  endtask
  // Supply drop and rise
  task automatic por_cycle();
    @(posedge clk) supply_on <= 1'b0;
    cyc(5);
    chk({7'h00, sys_reset_n}, 8'h00);
    @(posedge clk) supply_on <= 1'b1;
    wait_run();
    chk({7'h00, n >= 8}, 8'h01);
  endtask
  // Deep sleep entry with detector checks
  task automatic enter_ds(input logic [7:0] c);
    @(posedge clk) cfg <= c;
    wr_reg(ADDR_MODE, 8'h01);
    cyc(3);
    chk({6'h00, core_on, main_on}, {7'h00, c[2]});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h6416));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    wait_run();
    rd_reg(ADDR_RESET_CONTROL, 8'h00);
    wr_reg(ADDR_RESET_CONTROL, 8'h03);
    rd_reg(ADDR_RESET_CONTROL, 8'h03);
    for (int i = 0; i < 4; i++) begin
      r0 = 8'($urandom);
      wr_reg(ADDR_HOLD_0 + 12'(i % 2), r0);
      rd_reg(ADDR_HOLD_0 + 12'(i % 2), r0);
    end
    wr_reg(12'h0f50, 8'h5a);
    rd_reg(12'h0f50, 8'h00);
    // Short pin pulses of one and two cycles
    for (int g = 1; g <= 2; g++) begin
      @(posedge clk) pin_low <= 1'b1;
      repeat (g) @(posedge clk);
      pin_low <= 1'b0;
      cyc(6);
      chk({7'h00, sys_reset_n}, 8'h01);
    end
    @(posedge clk) pin_low <= 1'b1;
    cyc(8);
    chk({7'h00, sys_reset_n}, 8'h00);
    rd_reg(ADDR_STATUS, 8'h31);
    @(posedge clk) pin_low <= 1'b0;
    wait_run();
    rd_reg(ADDR_RESET_CONTROL, 8'h03);
    // Core brown-out, flags read as software would
    @(posedge clk) core_sag <= 1'b1;
    cyc(4);
    chk({7'h00, sys_reset_n}, 8'h00);
    rd_reg(ADDR_STATUS, 8'h21);
    rd_reg(ADDR_RESET_CONTROL, flags_exp(1'b1, 1'b0));
    @(posedge clk) core_sag <= 1'b0;
    wait_run();
    chk({7'h00, n >= 8}, 8'h01);
    // Deep sleep with main detector enabled
    r0 = 8'($urandom);
    r1 = 8'($urandom);
    wr_reg(ADDR_HOLD_0, r0);
    wr_reg(ADDR_HOLD_1, r1);
    wr_reg(ADDR_RESET_CONTROL, 8'h03);
    enter_ds(8'h04);
    @(posedge clk) main_dip <= 1'b1;
    cyc(5);
    chk({7'h00, sys_reset_n}, 8'h01);
    rd_reg(ADDR_STATUS, 8'h0e);
    @(posedge clk) main_sag <= 1'b1;
    cyc(3);
    chk({5'h00, sys_reset_n, pins_tristate, ds_act}, 8'h02);
    @(posedge clk) begin
      main_sag <= 1'b0;
      main_dip <= 1'b0;
    end
    wait_run();
    chk({7'h00, wake_flag}, 8'h00);
    rd_reg(ADDR_HOLD_0, 8'h00);
    rd_reg(ADDR_HOLD_1, 8'h00);
    rd_reg(ADDR_RESET_CONTROL, 8'h00);
    wr_reg(ADDR_MODE, 8'h04);
    cyc(2);
    chk({7'h00, pins_tristate}, 8'h00);
    // Normal wake from deep sleep sets the wake flag
    enter_ds(8'h04);
    @(posedge clk) wake_event <= 1'b1;
    @(posedge clk) wake_event <= 1'b0;
    cyc(2);
    chk({6'h00, ds_act, wake_flag}, 8'h01);
    rd_reg(ADDR_MODE, 8'h02);
    wr_reg(ADDR_MODE, 8'h00);
    // Deep sleep with main detector disabled, then power cycle
    wr_reg(ADDR_RESET_CONTROL, 8'h03);
    enter_ds(8'h00);
    @(posedge clk) main_sag <= 1'b1;
    cyc(5);
    chk({7'h00, sys_reset_n}, 8'h01);
    @(posedge clk) main_sag <= 1'b0;
    por_cycle();
    rd_reg(ADDR_RESET_CONTROL, 8'h00);
    // Low-voltage variant
    @(posedge clk) begin
      lv <= 1'b1;
      cfg <= 8'h04;
    end
    wr_reg(ADDR_RESET_CONTROL, 8'h03);
    cyc(3);
    chk({6'h00, core_on, main_on}, 8'h01);
    @(posedge clk) core_sag <= 1'b1;
    cyc(5);
    chk({7'h00, sys_reset_n}, 8'h01);
    @(posedge clk) core_sag <= 1'b0;
    por_cycle();
    rd_reg(ADDR_RESET_CONTROL, 8'h00);
    test_done();
  end
endmodule
